// ---- hw/ecc2_control.sv ----
// Behaviour
// - Tone off bit stops tone detection
// - Both tone off bits power down tone processors
// - Phase qualifier off: any tone triggers
// - Phase qualifier on: reversals required
// - Auto bypass enters bypass on tone
// - Auto bypass clear: algorithm keeps running
// - Narrow-band off bit disables detector
// - Filter off bit bypasses both offset filters
// - Filter bit clear removes DC offset
// - Bypass passes inputs unless muted, clears coefficients, stops adaptation
// - Gated flag needs auto bypass and tone
module ecc2_control (
  input  wire logic                         CLK_SYS,
  input  wire logic                         RST,
  input  wire logic [7:0]                   ADDRESS,
  input  wire logic                         READ,
  input  wire logic                         WRITE,
  input  wire logic [31:0]                  WRITEDATA,
  input  wire logic [3:0]                   BYTEENABLE,
  output      logic [31:0]                  READDATA,
  output      logic                         WAITREQUEST,
  input  wire ecc2_pkg::ecc2_det_type [1:0] DET,
  input  wire ecc2_pkg::ecc2_pcm_in_type [1:0] PCM_IN,
  output      logic [1:0][15:0]             SOUT,
  output      logic [1:0][15:0]             ROUT,
  output      logic [1:0]                   OUT_VALID,
  output      logic [1:0][15:0]             SIN_CLEAN,
  output      logic [1:0][15:0]             RIN_CLEAN,
  output      ecc2_pkg::ecc2_feat_type [1:0] FEAT,
  output      logic                         TONE_POWER_DOWN
);

`include "ecc2_cfg.svh"

  // ****************************************************************
  // Local types
  // ****************************************************************

  // Result of decoding a bus address
  typedef struct packed {
    logic hit;     // Address is mapped
    logic chan;    // 0 is canceller A, 1 is canceller B
    logic status;  // Status register rather than control
  } ecc2_sel_type;

  // Whole state of the block
  typedef struct packed {
    logic                              ack;        // Bus answer cycle
    logic [31:0]                       rdata;      // Read data
    ecc2_pkg::ecc2_ctrl_type [1:0]     ctrl;       // Feature control
    logic [1:0][15:0]                  sout;       // Send outputs
    logic [1:0][15:0]                  rout;       // Receive outputs
    logic [1:0]                        valid;      // Output strobes
    ecc2_pkg::ecc2_feat_type [1:0]     feat;       // Core enables
    logic                              tone_pd;    // Tone power down
  } ecc2_state_type;

  // ****************************************************************
  // Signals
  // ****************************************************************
  ecc2_state_type                state_reg;   // Registered state
  ecc2_state_type                state_next;  // Next state
  ecc2_sel_type                  sel;         // Decoded bus address
  ecc2_pkg::ecc2_feat_type [1:0] feat_now;    // Enables this cycle
  logic [1:0][15:0]              sin_clean;   // Filtered send input
  logic [1:0][15:0]              rin_clean;   // Filtered receive input

  // ****************************************************************
  // Address decoding
  // ****************************************************************

  // Match a byte address against a register index
  function automatic logic idx_match(input logic [7:0] addr, input logic [7:0] idx);
    idx_match = (addr[1:0] == 2'b00) && (addr[7:2] == idx[5:0]);
  endfunction

  // Map a byte address to a register selection
  function automatic ecc2_sel_type decode(input logic [7:0] addr);
    decode = '0;
    if (idx_match(addr, `ECC2_CTRL_A_IDX)) begin
      decode.hit = 1'b1;
    end else if (idx_match(addr, `ECC2_CTRL_B_IDX)) begin
      decode.hit  = 1'b1;
      decode.chan = 1'b1;
    end else if (idx_match(addr, `ECC2_STAT_A_IDX)) begin
      decode.hit    = 1'b1;
      decode.status = 1'b1;
    end else if (idx_match(addr, `ECC2_STAT_B_IDX)) begin
      decode.hit    = 1'b1;
      decode.chan   = 1'b1;
      decode.status = 1'b1;
    end
  endfunction

  // Build the status byte of one canceller
  function automatic logic [7:0] status_byte(input ecc2_pkg::ecc2_feat_type f);
    status_byte                   = 8'h00;
    status_byte[`ECC2_STAT_NB]     = f.narrowband_seen;
    status_byte[`ECC2_STAT_GATED]  = f.gated_tone_flag;
    status_byte[`ECC2_STAT_BYPASS] = f.bypass;
    status_byte[`ECC2_STAT_TONE]   = f.tone_qualified;
  endfunction

  // ****************************************************************
  // Offset nulling filters, one per input path per canceller
  // ****************************************************************
  generate
    for (genvar c = 0; c < 2; c++) begin : g_chan
      // Send input path
      ecc2_offset_filter u_sin_filter (
        .clk        (CLK_SYS),
        .rst        (RST),
        .active     (~state_reg.ctrl[c].offset_filter_off),
        .strobe     (PCM_IN[c].strobe),
        .sample_in  (PCM_IN[c].sin),
        .sample_out (sin_clean[c])
      );
      // Receive input path
      ecc2_offset_filter u_rin_filter (
        .clk        (CLK_SYS),
        .rst        (RST),
        .active     (~state_reg.ctrl[c].offset_filter_off),
        .strobe     (PCM_IN[c].strobe),
        .sample_in  (PCM_IN[c].rin),
        .sample_out (rin_clean[c])
      );
    end
  endgenerate

  // ****************************************************************
  // Feature decoding from the control registers
  // ****************************************************************
  // Purely combinational; registered once below so that every
  // enable seen by the core comes straight from a flip-flop
  always_comb begin
    feat_now = '0;
    for (int c = 0; c < 2; c++) begin
      // Tone detector runs only while its off bit is clear
      feat_now[c].tone_detect_en = ~state_reg.ctrl[c].tone_detect_off;
      // Phase reversals required unless qualification is off
      feat_now[c].phase_qual_en  = ~state_reg.ctrl[c].phase_reversal_qual_off;
      // A tone counts only when detection runs and it qualifies
      feat_now[c].tone_qualified = feat_now[c].tone_detect_en & DET[c].tone_2100
                                   & (state_reg.ctrl[c].phase_reversal_qual_off
                                      | DET[c].phase_reversal);
      // Bypass only with auto bypass on; otherwise keep cancelling
      feat_now[c].bypass         = state_reg.ctrl[c].auto_tone_bypass
                                   & feat_now[c].tone_qualified;
      // Bypass zeroes coefficients and freezes adaptation
      feat_now[c].coef_clear     = feat_now[c].bypass;
      feat_now[c].adapt_hold     = feat_now[c].bypass;
      // Gated flag follows the same two conditions
      feat_now[c].gated_tone_flag = state_reg.ctrl[c].auto_tone_bypass
                                    & feat_now[c].tone_qualified;
      // Nonlinear processor switch, for conformance testing
      feat_now[c].nlp_en         = ~state_reg.ctrl[c].nonlinear_proc_off;
      // Narrow-band detector switch and its gated report
      feat_now[c].narrowband_en  = ~state_reg.ctrl[c].narrowband_detect_off;
      feat_now[c].narrowband_seen = feat_now[c].narrowband_en & DET[c].narrowband;
    end
  end

  // ****************************************************************
  // Next state: bus slave, feature enables and output samples
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    sel        = decode(ADDRESS);

    // Register bus: one wait cycle, then a one-cycle answer
    if (state_reg.ack) begin
      // Answer cycle: waitrequest is low, the request is taken now
      state_next.ack = 1'b0;
      if (WRITE && sel.hit && !sel.status && BYTEENABLE[0]) begin
        // Control write; status registers ignore writes.
        // Canceller B takes each write as it comes; the repeat
        // that software issues simply writes the same value again
        state_next.ctrl[sel.chan] = WRITEDATA[7:0];
      end
    end else if (READ || WRITE) begin
      // First cycle of a request: prepare the answer
      state_next.ack   = 1'b1;
      state_next.rdata = 32'h0000_0000;
      if (READ && sel.hit) begin
        if (sel.status) begin
          state_next.rdata[7:0] = status_byte(state_reg.feat[sel.chan]);
        end else begin
          state_next.rdata[7:0] = state_reg.ctrl[sel.chan];
        end
      end
    end

    // Enables to the core, registered
    state_next.feat = feat_now;

    // Tone processors sleep only when both cancellers disable them
    state_next.tone_pd = state_reg.ctrl[0].tone_detect_off
                         & state_reg.ctrl[1].tone_detect_off;

    // Output samples, one update per input strobe
    for (int c = 0; c < 2; c++) begin
      state_next.valid[c] = PCM_IN[c].strobe;
      if (PCM_IN[c].strobe) begin
        // Send output: mute first, then bypass, else algorithm
        if (state_reg.ctrl[c].send_out_mute) begin
          state_next.sout[c] = `ECC2_QUIET_CODE;
        end else if (feat_now[c].bypass) begin
          state_next.sout[c] = PCM_IN[c].sin;
        end else begin
          state_next.sout[c] = PCM_IN[c].ec_sout;
        end
        // Receive output: same order of precedence
        if (state_reg.ctrl[c].receive_out_mute) begin
          state_next.rout[c] = `ECC2_QUIET_CODE;
        end else if (feat_now[c].bypass) begin
          state_next.rout[c] = PCM_IN[c].rin;
        end else begin
          state_next.rout[c] = PCM_IN[c].ec_rout;
        end
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state_reg         <= '0;
      state_reg.ctrl[0] <= `ECC2_CTRL_RESET;
      state_reg.ctrl[1] <= `ECC2_CTRL_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // Outputs, all straight from flip-flops
  // ****************************************************************
  // Waitrequest stays high while idle, which Avalon permits
  assign WAITREQUEST     = ~state_reg.ack;
  assign READDATA        = state_reg.rdata;
  assign SOUT            = state_reg.sout;
  assign ROUT            = state_reg.rout;
  assign OUT_VALID       = state_reg.valid;
  assign FEAT            = state_reg.feat;
  assign TONE_POWER_DOWN = state_reg.tone_pd;
  assign SIN_CLEAN       = sin_clean;
  assign RIN_CLEAN       = rin_clean;

endmodule

// ---- hw/ecc2_cfg.svh ----
`ifndef ECC2_CFG_SVH
`define ECC2_CFG_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define ECC2_CTRL_A_IDX    8'h01
`define ECC2_CTRL_B_IDX    8'h21
`define ECC2_STAT_A_IDX    8'h02
`define ECC2_STAT_B_IDX    8'h22

// ****************************************************************
// Feature control field positions and reset value
// ****************************************************************
`define ECC2_BIT_TONE_OFF  7
`define ECC2_BIT_PHASE_OFF 6
`define ECC2_BIT_NLP_OFF   5
`define ECC2_BIT_AUTO_BYP  4
`define ECC2_BIT_NB_OFF    3
`define ECC2_BIT_HPF_OFF   2
`define ECC2_BIT_MUTE_S    1
`define ECC2_BIT_MUTE_R    0
`define ECC2_CTRL_RESET    8'h00

// ****************************************************************
// Status field positions and sample constants
// ****************************************************************
`define ECC2_STAT_NB       0
`define ECC2_STAT_GATED    1
`define ECC2_STAT_BYPASS   2
`define ECC2_STAT_TONE     6
`define ECC2_QUIET_CODE    16'h0000
`define ECC2_HPF_SHIFT     8

`endif

// ---- hw/ecc2_pkg.sv ----
package ecc2_pkg;

  // ****************************************************************
  // Feature control register, bit 7 first
  // ****************************************************************
  typedef struct packed {
    logic tone_detect_off;          // Bit 7
    logic phase_reversal_qual_off;  // Bit 6
    logic nonlinear_proc_off;       // Bit 5
    logic auto_tone_bypass;         // Bit 4
    logic narrowband_detect_off;    // Bit 3
    logic offset_filter_off;        // Bit 2
    logic send_out_mute;            // Bit 1
    logic receive_out_mute;         // Bit 0
  } ecc2_ctrl_type;

  // Raw reports of the detectors of one canceller
  typedef struct packed {
    logic tone_2100;       // Tone present
    logic phase_reversal;  // Periodic phase reversals seen
    logic narrowband;      // Narrow-band signal on receive input
  } ecc2_det_type;

  // Samples of one canceller entering the block
  typedef struct packed {
    logic        strobe;   // One-cycle sample strobe
    logic [15:0] sin;      // Send input
    logic [15:0] rin;      // Receive input
    logic [15:0] ec_sout;  // Canceller algorithm send output
    logic [15:0] ec_rout;  // Canceller algorithm receive output
  } ecc2_pcm_in_type;

  // Feature enables driven to the canceller core
  typedef struct packed {
    logic tone_detect_en;   // Tone detector running
    logic phase_qual_en;    // Phase reversals required
    logic nlp_en;           // Nonlinear processor running
    logic narrowband_en;    // Narrow-band detector running
    logic bypass;           // Canceller in bypass
    logic coef_clear;       // Zero adaptive coefficients
    logic adapt_hold;       // Stop adaptation
    logic gated_tone_flag;  // Tone seen with auto bypass on
    logic tone_qualified;   // Qualified tone seen
    logic narrowband_seen;  // Enabled narrow-band detection
  } ecc2_feat_type;

  // Offset filter state
  typedef struct packed {
    logic [23:0] acc;  // DC estimate, fraction below bit 8
    logic [15:0] out;  // Cleaned sample
  } ecc2_filt_state_type;

endpackage

// ---- hw/ecc2_offset_filter.sv ----
module ecc2_offset_filter (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        active,
  input  wire logic        strobe,
  input  wire logic [15:0] sample_in,
  output      logic [15:0] sample_out
);

`include "ecc2_cfg.svh"

  ecc2_pkg::ecc2_filt_state_type state_reg;   // Registered state
  ecc2_pkg::ecc2_filt_state_type state_next;  // Next state
  logic [15:0]                   dc_now;      // Current DC estimate
  logic [15:0]                   diff;        // Input less DC

  // ****************************************************************
  // First-order DC removal, one update per sample strobe
  // ****************************************************************
  // Wraps on overflow rather than saturating; inputs near full
  // scale with a large offset will alias, a known limitation
  always_comb begin
    state_next = state_reg;
    dc_now     = state_reg.acc[23:`ECC2_HPF_SHIFT];
    diff       = sample_in - dc_now;
    if (strobe) begin
      if (active) begin
        // Filter running: subtract estimate and track it
        state_next.out = diff;
        state_next.acc = state_reg.acc + {{8{diff[15]}}, diff};
      end else begin
        // Filter bypassed: pass sample, restart estimate
        state_next.out = sample_in;
        state_next.acc = 24'h00_0000;
      end
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sample_out = state_reg.out;

endmodule

// ---- testbench/ecc2_control_chk.sv ----
`include "ecc2_cfg.svh"

module ecc2_control_chk (
  input wire logic                            CLK_SYS,
  input wire logic                            RST,
  input wire logic [7:0]                      ADDRESS,
  input wire logic                            READ,
  input wire logic                            WRITE,
  input wire logic [31:0]                     WRITEDATA,
  input wire logic [3:0]                      BYTEENABLE,
  input wire logic                            WAITREQUEST,
  input wire ecc2_pkg::ecc2_det_type [1:0]    DET,
  input wire ecc2_pkg::ecc2_pcm_in_type [1:0] PCM_IN,
  input wire logic [1:0][15:0]                SOUT,
  input wire logic [1:0]                      OUT_VALID,
  input wire logic [1:0][15:0]                SIN_CLEAN,
  input wire ecc2_pkg::ecc2_feat_type [1:0]   FEAT,
  input wire logic                            TONE_POWER_DOWN
);
  // ****************************************************************
  // Shadow of the control bytes
  // ****************************************************************
  ecc2_pkg::ecc2_ctrl_type [1:0] sh_reg;  // Last landed control bytes
  logic                          up_reg;  // High from the first edge after reset
  logic                          land;    // Write accepted at this edge
  assign land = WRITE && !WAITREQUEST && BYTEENABLE[0];
  // Tracks writes so that feature checks need no view of the body
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      sh_reg <= '0;
      up_reg <= 1'b0;
    end else begin
      up_reg <= 1'b1;
      if (land && ADDRESS == (`ECC2_CTRL_A_IDX << 2)) sh_reg[0] <= WRITEDATA[7:0];
      if (land && ADDRESS == (`ECC2_CTRL_B_IDX << 2)) sh_reg[1] <= WRITEDATA[7:0];
    end
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  // ****************************************************************
  // Bus and group checks
  // ****************************************************************
  chk_wait_answer: assert property ((READ || WRITE) && WAITREQUEST |=> !WAITREQUEST)
    else $error("request not answered in the next cycle");
  chk_wait_single: assert property (!WAITREQUEST |=> WAITREQUEST)
    else $error("waitrequest low for more than one cycle");
  chk_power_down: assert property (
    up_reg |-> TONE_POWER_DOWN == $past(sh_reg[0][7] && sh_reg[1][7]))
    else $error("tone power down differs from both off bits");
  // ****************************************************************
  // Per canceller feature checks
  // ****************************************************************
  for (genvar c = 0; c < 2; c++) begin : g_can
    chk_tone_enable: assert property (
      up_reg |-> FEAT[c].tone_detect_en == !$past(sh_reg[c].tone_detect_off)
      && FEAT[c].nlp_en == !$past(sh_reg[c].nonlinear_proc_off))
      else $error("tone or nonlinear enable wrong");
    chk_tone_qual: assert property (
      up_reg |-> FEAT[c].tone_qualified == $past(!sh_reg[c].tone_detect_off && DET[c].tone_2100
      && (sh_reg[c].phase_reversal_qual_off || DET[c].phase_reversal)))
      else $error("tone qualification wrong");
    chk_bypass_gate: assert property (
      up_reg |-> FEAT[c].bypass == (FEAT[c].tone_qualified && $past(sh_reg[c].auto_tone_bypass))
      && FEAT[c].gated_tone_flag == FEAT[c].bypass)
      else $error("bypass or gated flag wrong");
    chk_bypass_core: assert property (FEAT[c].bypass |-> FEAT[c].coef_clear && FEAT[c].adapt_hold)
      else $error("bypass without coefficient clear and hold");
    chk_nb_enable: assert property (
      up_reg |-> FEAT[c].narrowband_en == !$past(sh_reg[c].narrowband_detect_off)
      && FEAT[c].narrowband_seen == $past(!sh_reg[c].narrowband_detect_off && DET[c].narrowband))
      else $error("narrow-band enable wrong");
    chk_out_pulse: assert property (up_reg |-> OUT_VALID[c] == $past(PCM_IN[c].strobe))
      else $error("output valid not one cycle after strobe");
    chk_mute_send: assert property (
      OUT_VALID[c] && $past(sh_reg[c].send_out_mute) |-> SOUT[c] == 16'h0000)
      else $error("muted send output not quiet");
    chk_filter_off: assert property (
      OUT_VALID[c] && $past(sh_reg[c].offset_filter_off) |-> SIN_CLEAN[c] == $past(PCM_IN[c].sin))
      else $error("bypassed filter changed the sample");
  end
endmodule

bind ecc2_control ecc2_control_chk i_chk (
  .CLK_SYS(CLK_SYS), .RST(RST), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
  .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .WAITREQUEST(WAITREQUEST), .DET(DET),
  .PCM_IN(PCM_IN), .SOUT(SOUT), .OUT_VALID(OUT_VALID), .SIN_CLEAN(SIN_CLEAN), .FEAT(FEAT),
  .TONE_POWER_DOWN(TONE_POWER_DOWN)
);

// ---- testbench/test_ecc2_control.sv ----
module test_ecc2_control;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic                            clk_sys, rst, read, write, wait_req, power_down;
  logic [7:0]                      address;
  logic [31:0]                     writedata, readdata, rd;
  logic [3:0]                      byteenable;
  ecc2_pkg::ecc2_det_type [1:0]    det;
  ecc2_pkg::ecc2_pcm_in_type [1:0] pcm_in;
  logic [1:0][15:0]                sout, rout, sin_clean, rin_clean;
  logic [1:0]                      out_valid;
  ecc2_pkg::ecc2_feat_type [1:0]   feat;
  int                              mismatches, check_count, cycles;
  logic [7:0] tab [11] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80, 8'h50, 8'hd0};
  logic [7:0] stab [6] = '{8'h04, 8'h14, 8'h17, 8'h06, 8'h05, 8'h54};  // Filter bypassed in all

  ecc2_control i_dut (
    .CLK_SYS(clk_sys), .RST(rst), .ADDRESS(address), .READ(read), .WRITE(write),
    .WRITEDATA(writedata), .BYTEENABLE(byteenable), .READDATA(readdata), .WAITREQUEST(wait_req),
    .DET(det), .PCM_IN(pcm_in), .SOUT(sout), .ROUT(rout), .OUT_VALID(out_valid),
    .SIN_CLEAN(sin_clean), .RIN_CLEAN(rin_clean), .FEAT(feat), .TONE_POWER_DOWN(power_down)
  );

  // Free running clock at 25 MHz
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Hang guard: the tests need well under half of this
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 10000) begin
      mismatches++;
      print_verdict();
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One Avalon cycle; values read at an edge are the ones the edge samples
  task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    address   <= addr;
    writedata <= data;
    read      <= !wr;
    write     <= wr;
    @(posedge clk_sys);
    while (wait_req !== 1'b0) @(posedge clk_sys);
    rd = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    @(posedge clk_sys);  // Keeps the next request off this time step
  endtask

  // Second canceller takes each byte twice, 360 ns or more apart
  task automatic wr_ctrl(input int c, input logic [7:0] v);
    bus(1'b1, c ? 8'h84 : 8'h04, {24'h00_0000, v});
    if (c == 1) begin
      repeat (9) @(posedge clk_sys);
      bus(1'b1, 8'h84, {24'h00_0000, v});
    end
  endtask

  function automatic ecc2_pkg::ecc2_feat_type exp_feat(input ecc2_pkg::ecc2_ctrl_type k,
                                                       input ecc2_pkg::ecc2_det_type d);
    ecc2_pkg::ecc2_feat_type f;
    logic q;
    q = !k.tone_detect_off && d.tone_2100 && (k.phase_reversal_qual_off || d.phase_reversal);
    f.tone_detect_en  = !k.tone_detect_off;
    f.phase_qual_en   = !k.phase_reversal_qual_off;
    f.nlp_en          = !k.nonlinear_proc_off;
    f.narrowband_en   = !k.narrowband_detect_off;
    f.bypass          = k.auto_tone_bypass && q;
    f.coef_clear      = f.bypass;
    f.adapt_hold      = f.bypass;
    f.gated_tone_flag = f.bypass;
    f.tone_qualified  = q;
    f.narrowband_seen = !k.narrowband_detect_off && d.narrowband;
    return f;
  endfunction

  // Strobe one sample set in; returns where the outputs are sampled
  task automatic pcm(input int c, input logic [15:0] x);
    pcm_in[c] <= {1'b1, x, ~x, x ^ 16'h0f0f, x + 16'h0001};
    @(posedge clk_sys);
    pcm_in[c].strobe <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [15:0] s, r;
    ecc2_pkg::ecc2_feat_type f;
    {rst, read, write, address, writedata, det, pcm_in} = '0;
    rst        = 1'b1;
    byteenable = 4'hf;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    bus(1'b0, 8'h04, '0); check("ctrl a reset", 32'h0000_0000, rd);
    bus(1'b0, 8'h84, '0); check("ctrl b reset", 32'h0000_0000, rd);
    bus(1'b0, 8'h40, '0); check("unmapped read", 32'h0000_0000, rd);
    byteenable <= 4'h0;
    bus(1'b1, 8'h04, 32'h0000_00ff);
    byteenable <= 4'hf;
    bus(1'b0, 8'h04, '0); check("masked write", 32'h0000_0000, rd);
    $display("test bus done");
    // Every bit alone and some mixes, against every detector report
    for (int c = 0; c < 2; c++) begin
      for (int i = 0; i < 11; i++) begin
        wr_ctrl(c, tab[i]);
        bus(1'b0, c ? 8'h84 : 8'h04, '0); check("ctrl readback", {24'h00_0000, tab[i]}, rd);
        for (int d = 0; d < 8; d++) begin
          det[c] <= 3'(d);
          repeat (2) @(posedge clk_sys);
          f = exp_feat(tab[i], 3'(d));
          check("feature", 32'(f), 32'(feat[c]));
        end
      end
    end
    det[0] <= 3'b110;
    wr_ctrl(0, 8'h50);
    bus(1'b1, 8'h08, 32'h0000_00ff);  // Status must ignore this write
    bus(1'b0, 8'h08, '0); check("gated status", 32'h0000_0046, rd);
    wr_ctrl(0, 8'h40);
    bus(1'b0, 8'h08, '0); check("ungated status", 32'h0000_0040, rd);
    bus(1'b0, 8'h88, '0); check("status b", 32'h0000_0001, rd);
    $display("test features done");
    wr_ctrl(0, 8'h80);
    wr_ctrl(1, 8'h80);
    repeat (2) @(posedge clk_sys);
    check("power down", 32'h0000_0001, 32'(power_down));
    wr_ctrl(1, 8'h00);
    repeat (2) @(posedge clk_sys);
    check("power up", 32'h0000_0000, 32'(power_down));
    // Mid-run reset must bring control byte A back to zero
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    bus(1'b0, 8'h04, '0); check("ctrl a after reset", 32'h0000_0000, rd);
    $display("test power down done");
    // Output selection with offset filters bypassed
    for (int c = 0; c < 2; c++) begin
      for (int i = 0; i < 12; i++) begin
        det[c] <= i[0] ? 3'b110 : 3'b100;
        wr_ctrl(c, stab[i / 2]);
        repeat (2) @(posedge clk_sys);
        pcm(c, 16'h1234);
        f = exp_feat(stab[i / 2], i[0] ? 3'b110 : 3'b100);
        s = stab[i / 2][1] ? 16'h0000 : f.bypass ? 16'h1234 : 16'h1d3b;
        r = stab[i / 2][0] ? 16'h0000 : f.bypass ? 16'hedcb : 16'h1235;
        check("send out", 32'(s), 32'(sout[c]));
        check("receive out", 32'(r), 32'(rout[c]));
        check("out valid", 32'h0000_0001, 32'(out_valid[c]));
        check("send clean", 32'h0000_1234, 32'(sin_clean[c]));
        check("receive clean", 32'h0000_edcb, 32'(rin_clean[c]));
      end
    end
    $display("test outputs done");
    // Filter on from a cleared estimate: first sample whole, then DC decays
    wr_ctrl(0, 8'h00);
    pcm(0, 16'h1000);
    check("first filtered", 32'h0000_1000, 32'(sin_clean[0]));
    pcm_in[0].strobe <= 1'b1;
    repeat (2000) @(posedge clk_sys);
    pcm_in[0].strobe <= 1'b0;
    @(posedge clk_sys);
    check("dc removed", 32'h0000_0001, 32'(sin_clean[0] < 16'h0010));
    $display("test offset filter done");
    print_verdict();
  end
endmodule
